// file: hdl/ace_engine.sv
// ace_engine: ata task-file command interpreter behind an ahb-lite slave
// assumes: one clock; media side answers med_rdata in the cycle of a rd pulse
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps

module ace_engine #(
   parameter logic [15:0] NCYL = 16'h0100, // default cylinders
   parameter logic [15:0] NHEAD = 16'h0004, // default heads
   parameter logic [15:0] NSPT = 16'h0020, // default sectors per track
   parameter logic [31:0] TOTS_RST = 32'h0002_0000 // total sectors after reset
) (
   input logic hclk, // bus clock
   input logic hresetn, // async reset, low
   input logic hsel, // slave select
   input logic [31:0] haddr, // byte address
   input logic [1:0] htrans, // transfer type
   input logic hwrite, // write when high
   input logic [2:0] hsize, // word only
   input logic hready, // bus ready in
   input logic [31:0] hwdata, // write data
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // always ready
   output logic hresp, // always okay
   output logic irq_n, // interrupt request, low
   output ace_pkg::ace_med_s med, // media strobes and address
   input logic [15:0] med_rdata // current media word
);
   import ace_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // state
   ace_state_e st_r;
   ace_cmd_s cmd_r;
   ace_med_s med_r;
   logic [7:0] feat_r, sc_r, sn_r, cyl_r, cyh_r, dh_r, err_r, mult_r, blk_r, lob_r;
   logic [9:0] wc_r;
   logic [8:0] ns_r;
   logic [31:0] tot_r, hrdata_r;
   logic [1:0] pw_r;
   logic [7:0] wa_r;
   logic wp_r, srst_r, nien_r, b8_r, nopor_r, apd_r, irqp_r, irq_n_r, errf_r;

   // identify block; words not listed are zero
   function automatic logic [15:0] id_word(input logic [7:0] w, input logic [7:0] m,
      input logic [31:0] t);
      unique case (w)
         8'd0: id_word = ID_GCFG;
         8'd1: id_word = NCYL;
         8'd3: id_word = NHEAD;
         8'd6: id_word = NSPT;
         8'd7: id_word = t[31:16];
         8'd8: id_word = t[15:0];
         8'd20: id_word = ID_BTYPE;
         8'd21: id_word = ID_BSIZE;
         8'd22: id_word = ID_ECC;
         8'd47: id_word = ID_MMAX;
         8'd49: id_word = ID_CAPS;
         8'd51: id_word = ID_PIO;
         8'd59: id_word = ID_MVAL | {8'h00, m};
         8'd60: id_word = t[15:0];
         8'd61: id_word = t[31:16];
         default: id_word = 16'h0000; // includes dma timing word 52
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus decode; writes land in the data phase, reads are fetched in the address phase
   wire ap = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);
   wire ard = ap & ~hwrite;
   wire [7:0] aa = haddr[7:0];
   wire busy = srst_r | st_r inside {S_EXEC, S_PROG, S_VRFY};
   wire drq = st_r == S_XFER;
   wire tf_ok = wp_r & ~busy & ~drq;
   wire stat_rd = ard & (aa == RA_CMD);
   wire cmd_wr = tf_ok & (wa_r == RA_CMD);
   wire dctl_wr = wp_r & (wa_r == RA_DCTL);
   wire [7:0] stat = {busy, ~busy, 2'b01, drq, 2'b00, errf_r};
   wire [7:0] mode = {1'b0, pw_r, apd_r, nopor_r, b8_r, mult_r[1:0]};

   ////////////////////////////////////////////////////////////////////////////
   // transfer bookkeeping
   wire rd_dir = cmd_r.cls inside {CL_RD, CL_ID, CL_BRD};
   wire [27:0] lba = {dh_r[3:0], cyh_r, cyl_r, sn_r};
   wire [27:0] lba_inc = lba + 28'h000_0001;
   wire in_rng = {4'h0, lba} < tot_r;
   // 8-bit mode doubles the accesses per sector
   wire [9:0] wlast = ((cmd_r.lng ? WPS_LONG : WPS_STD) << b8_r) - 10'd1;
   wire rd_take = ard & (aa == RA_DATA) & rd_dir;
   wire wr_take = wp_r & (wa_r == RA_DATA) & ~rd_dir;
   wire take = drq & (rd_take | wr_take);
   wire sec_end = take & (wc_r == wlast);
   wire last_sec = ns_r == 9'd1;
   wire blk_end = ~cmd_r.mlt | (blk_r + 8'd1 >= mult_r);
   wire word_edge = ~b8_r | wc_r[0];
   wire adv = (sec_end & cmd_r.cls inside {CL_RD, CL_WR}) | (st_r == S_VRFY);
   wire [7:0] iw = b8_r ? wc_r[8:1] : wc_r[7:0];
   wire [15:0] idw = id_word(iw, mult_r, tot_r);
   wire [15:0] rword = (cmd_r.cls == CL_ID) ? idw :
      (cmd_r.cls == CL_RD) ? med_rdata : 16'h0000;
   wire [15:0] dout = b8_r ? {8'h00, wc_r[0] ? rword[15:8] : rword[7:0]} : rword;

   ////////////////////////////////////////////////////////////////////////////
   // command outcome, valid while st_r is S_EXEC
   wire ex = st_r == S_EXEC;
   wire feat_ok = feat_r inside {FT_B8ON, FT_B8OFF, FT_NOPOR, FT_POR, FT_RLA, FT_ECC4};
   wire ex_idnf = cmd_r.cls inside {CL_RD, CL_WR, CL_VRF, CL_SEEK} & ~in_rng;
   wire ex_abrt = (cmd_r.cls == CL_BAD)
      | (cmd_r.cls == CL_FEAT & ~feat_ok)
      | (cmd_r.cls == CL_MULT & sc_r > MULT_RST)
      | (cmd_r.mlt & mult_r == 8'h00);
   wire ex_bad = ex_idnf | ex_abrt;
   wire ex_ok = ex & ~ex_bad;
   wire x_xfer = ex_ok & cmd_r.cls inside {CL_RD, CL_WR, CL_ID, CL_BRD, CL_BWR};
   wire x_vrf = ex_ok & cmd_r.cls == CL_VRF;
   // interrupt points: reads when data is ready, writes after programming
   wire irq_set = (ex & ~x_xfer & ~x_vrf)
      | (x_xfer & rd_dir)
      | (sec_end & rd_dir & ~last_sec & blk_end)
      | (st_r == S_PROG & (ns_r == 9'd0 | blk_r == 8'h00))
      | (st_r == S_VRFY & last_sec);

   ////////////////////////////////////////////////////////////////////////////
   // read mux; unmapped offsets read zero
   wire [31:0] rmux = (aa == RA_DATA) ? {16'h0000, drq & rd_dir ? dout : 16'h0000} :
      (aa == RA_FEAT) ? {24'h0, err_r} :
      (aa == RA_SCNT) ? {24'h0, sc_r} :
      (aa == RA_SNUM) ? {24'h0, sn_r} :
      (aa == RA_CYLL) ? {24'h0, cyl_r} :
      (aa == RA_CYLH) ? {24'h0, cyh_r} :
      (aa == RA_DRVH) ? {24'h0, dh_r} :
      (aa == RA_CMD || aa == RA_DCTL) ? {24'h0, stat} :
      (aa == RA_TOTS) ? tot_r :
      (aa == RA_MODE) ? {24'h0, mode} : 32'h0000_0000;

   // bus slave; zero wait states, so hreadyout and hresp are constant
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp_r <= 1'b0;
         wa_r <= 8'h00;
         hrdata_r <= 32'h0000_0000;
      end else begin
         wp_r <= ap & hwrite;
         wa_r <= aa;
         if (ard) begin
            hrdata_r <= rmux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command sequencer; soft reset parks it idle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= S_IDLE;
         cmd_r <= '0;
         wc_r <= 10'h000;
         ns_r <= 9'h000;
         blk_r <= 8'h00;
      end else if (srst_r) begin
         st_r <= S_IDLE;
      end else begin
         unique case (st_r)
            S_IDLE: if (cmd_wr) begin
               st_r <= S_EXEC;
               cmd_r <= ace_decode(hwdata[7:0]);
               ns_r <= (sc_r == 8'h00) ? NSEC_MAX : {1'b0, sc_r};
            end
            S_EXEC: begin
               wc_r <= 10'h000;
               blk_r <= 8'h00;
               if (cmd_r.cls inside {CL_ID, CL_BRD, CL_BWR}) begin
                  ns_r <= 9'd1;
               end
               // verify counts sectors with no data request
               st_r <= x_xfer ? S_XFER : x_vrf ? S_VRFY : S_IDLE;
            end
            S_XFER: if (take) begin
               wc_r <= sec_end ? 10'h000 : wc_r + 10'd1;
               if (sec_end) begin
                  ns_r <= ns_r - 9'd1;
                  blk_r <= blk_end ? 8'h00 : blk_r + 8'd1;
                  if (!rd_dir) begin
                     st_r <= S_PROG;
                  end else if (last_sec) begin
                     st_r <= S_IDLE;
                  end
               end
            end
            S_PROG: st_r <= (ns_r == 9'd0) ? S_IDLE : S_XFER;
            S_VRFY: begin
               ns_r <= ns_r - 9'd1;
               if (last_sec) begin
                  st_r <= S_IDLE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // task file; the engine wins over a host write in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         feat_r <= 8'h00;
         sc_r <= SC_RST;
         sn_r <= SN_RST;
         cyl_r <= 8'h00;
         cyh_r <= 8'h00;
         dh_r <= 8'h00;
         err_r <= ER_RST;
         errf_r <= 1'b0;
      end else if (srst_r) begin
         feat_r <= 8'h00;
         sc_r <= SC_RST;
         sn_r <= SN_RST;
         cyl_r <= 8'h00;
         cyh_r <= 8'h00;
         dh_r <= 8'h00;
         err_r <= ER_RST;
         errf_r <= 1'b0;
      end else if (adv) begin
         {dh_r[3:0], cyh_r, cyl_r, sn_r} <= lba_inc;
         sc_r <= sc_r - 8'd1;
      end else if (ex) begin
         errf_r <= ex_bad;
         err_r <= ex_idnf ? ER_IDNF : ex_abrt ? ER_ABRT : 8'h00;
         if (ex_ok && cmd_r.cls == CL_WEAR) begin
            sc_r <= 8'h00;
         end
         if (ex_ok && cmd_r.cls == CL_CHK) begin
            sc_r <= (pw_r == PW_SLP) ? 8'h00 : SC_AWAKE;
         end
      end else if (tf_ok) begin
         if (wa_r == RA_FEAT) feat_r <= hwdata[7:0];
         if (wa_r == RA_SCNT) sc_r <= hwdata[7:0];
         if (wa_r == RA_SNUM) sn_r <= hwdata[7:0];
         if (wa_r == RA_CYLL) cyl_r <= hwdata[7:0];
         if (wa_r == RA_CYLH) cyh_r <= hwdata[7:0];
         if (wa_r == RA_DRVH) dh_r <= hwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration and power; survives soft reset unless defaults are restored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         srst_r <= 1'b0;
         nien_r <= 1'b0;
         b8_r <= 1'b0;
         nopor_r <= 1'b0;
         apd_r <= 1'b0;
         mult_r <= MULT_RST;
         pw_r <= PW_ACT;
         tot_r <= TOTS_RST;
      end else begin
         if (dctl_wr) begin
            srst_r <= hwdata[DC_SRST];
            nien_r <= hwdata[DC_NIEN];
         end
         if (wp_r && wa_r == RA_TOTS) begin
            tot_r <= hwdata;
         end
         if (srst_r && !nopor_r) begin
            b8_r <= 1'b0;
            mult_r <= MULT_RST;
            apd_r <= 1'b0;
         end else if (cmd_wr) begin
            pw_r <= PW_ACT;
         end else if (ex_ok) begin
            unique case (cmd_r.cls)
               CL_FEAT: begin
                  if (feat_r == FT_B8ON) b8_r <= 1'b1;
                  if (feat_r == FT_B8OFF) b8_r <= 1'b0;
                  if (feat_r == FT_NOPOR) nopor_r <= 1'b1;
                  if (feat_r == FT_POR) nopor_r <= 1'b0;
               end
               CL_MULT: mult_r <= sc_r;
               CL_IDLE: begin
                  pw_r <= PW_IDLE;
                  apd_r <= sc_r != 8'h00;
               end
               CL_IDLI: pw_r <= PW_IDLE;
               CL_SLP, CL_STBY: pw_r <= PW_SLP;
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt: a completion in the cycle of a status read still sets the flag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irqp_r <= 1'b0;
         irq_n_r <= 1'b1;
      end else begin
         if (irq_set) begin
            irqp_r <= 1'b1;
         end else if (stat_rd || cmd_wr || srst_r) begin
            irqp_r <= 1'b0;
         end
         irq_n_r <= ~(irqp_r & ~nien_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // media strobes; only sector commands touch the media, buffer ones do not
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         med_r <= '0;
         lob_r <= 8'h00;
      end else begin
         med_r.rd <= take & (cmd_r.cls == CL_RD) & word_edge;
         med_r.wr <= take & (cmd_r.cls == CL_WR) & word_edge;
         med_r.prog <= sec_end & (cmd_r.cls == CL_WR);
         med_r.erase <= ~cmd_r.noer;
         med_r.vfy <= cmd_r.vfy;
         med_r.lba <= lba;
         if (wr_take && drq) begin
            med_r.wdata <= b8_r ? {hwdata[7:0], lob_r} : hwdata[15:0];
            lob_r <= hwdata[7:0];
         end
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign irq_n = irq_n_r;
   assign med = med_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   wire id_rd = ard & (aa == RA_DATA) & drq & (cmd_r.cls == CL_ID) & ~b8_r;
   id_gcfg_a: assert property (id_rd && wc_r == 10'd0 |=> hrdata[15:0] == ID_GCFG)
      else $error("identify word 0 wrong");
   id_caps_a: assert property (id_rd && wc_r == 10'd49 |=> hrdata[15:0] == ID_CAPS)
      else $error("identify capabilities wrong");
   id_total_a: assert property (id_rd && wc_r == 10'd7 |=> hrdata[15:0] == tot_r[31:16])
      else $error("identify total high half wrong");
   idle_apd_a: assert property (ex_ok && cmd_r.cls == CL_IDLE |=>
      st_r == S_IDLE && irqp_r && apd_r == ($past(sc_r) != 8'h00))
      else $error("idle did not complete");
   sleep_done_a: assert property (ex_ok && cmd_r.cls inside {CL_SLP, CL_STBY} |=>
      pw_r == PW_SLP && !busy && irqp_r)
      else $error("sleep or standby did not complete");
   sect_cnt_a: assert property (st_r == S_IDLE && cmd_wr && sc_r == 8'h00 |=>
      ns_r == NSEC_MAX)
      else $error("zero count not 256 sectors");
   vrf_nodrq_a: assert property (cmd_r.cls == CL_VRF |-> !drq)
      else $error("verify raised data request");
   wear_zero_a: assert property (ex_ok && cmd_r.cls == CL_WEAR |=> sc_r == 8'h00)
      else $error("wear level count not zero");
   feat_b8_a: assert property (ex_ok && cmd_r.cls == CL_FEAT && feat_r == FT_B8ON |=>
      b8_r)
      else $error("8-bit mode not enabled");
   nien_mask_a: assert property (nien_r |=> irq_n)
      else $error("interrupt passed while disabled");
   srst_hold_a: assert property (srst_r && !wp_r |=>
      st_r == S_IDLE && $stable(tot_r))
      else $error("soft reset touched config");
   bad_abort_a: assert property (ex && cmd_r.cls == CL_BAD |=>
      errf_r && err_r == ER_ABRT && irqp_r && !drq)
      else $error("unknown command not aborted");

   read_done_c: cover property (sec_end && rd_dir && last_sec ##1 st_r == S_IDLE);
   write_prog_c: cover property (med.prog ##1 st_r == S_IDLE);
   long_sect_c: cover property (sec_end && cmd_r.lng);
   srst_c: cover property (srst_r ##1 !srst_r);
endmodule

// file: hdl/ace_pkg.sv
// ace_pkg: offsets, bit positions, codes and types of the ata command engine
// assumes: ace_engine, the bench and the media model use it; all codes are 8-bit task-file values
package ace_pkg;
   // register byte offsets on the ahb slave
   localparam logic [7:0] RA_DATA = 8'h00; // data port
   localparam logic [7:0] RA_FEAT = 8'h04; // w features, r error
   localparam logic [7:0] RA_SCNT = 8'h08;
   localparam logic [7:0] RA_SNUM = 8'h0C;
   localparam logic [7:0] RA_CYLL = 8'h10;
   localparam logic [7:0] RA_CYLH = 8'h14;
   localparam logic [7:0] RA_DRVH = 8'h18;
   localparam logic [7:0] RA_CMD = 8'h1C; // w command, r status
   localparam logic [7:0] RA_DCTL = 8'h20; // w device control, r alt status
   localparam logic [7:0] RA_TOTS = 8'h24; // total sectors of the card
   localparam logic [7:0] RA_MODE = 8'h28; // read-only mode word
   // bit positions and the word transfer size
   localparam int DC_SRST = 2;
   localparam int DC_NIEN = 1;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // error codes, task-file and multiple-count reset values, and the awake sector count
   localparam logic [7:0] ER_ABRT = 8'h04;
   localparam logic [7:0] ER_IDNF = 8'h10;
   localparam logic [7:0] ER_RST = 8'h01;
   localparam logic [7:0] SC_RST = 8'h01;
   localparam logic [7:0] SN_RST = 8'h01;
   localparam logic [7:0] MULT_RST = 8'h01;
   localparam logic [7:0] SC_AWAKE = 8'hFF;
   // identify words
   localparam logic [15:0] ID_GCFG = 16'h848A;
   localparam logic [15:0] ID_BTYPE = 16'h0002;
   localparam logic [15:0] ID_BSIZE = 16'h0002;
   localparam logic [15:0] ID_ECC = 16'h0004;
   localparam logic [15:0] ID_MMAX = 16'h0001;
   localparam logic [15:0] ID_CAPS = 16'h0200;
   localparam logic [15:0] ID_PIO = 16'h0100;
   localparam logic [15:0] ID_MVAL = 16'h0100;
   // transfer sizes: sector lengths in 16-bit words, then the largest sector count
   localparam logic [9:0] WPS_STD = 10'h100;
   localparam logic [9:0] WPS_LONG = 10'h102;
   localparam logic [8:0] NSEC_MAX = 9'h100;
   // feature codes
   localparam logic [7:0] FT_B8ON = 8'h01, FT_RLA = 8'h55, FT_NOPOR = 8'h66;
   localparam logic [7:0] FT_B8OFF = 8'h81, FT_ECC4 = 8'hBB, FT_POR = 8'hCC;
   // power states
   localparam logic [1:0] PW_ACT = 2'h0, PW_IDLE = 2'h1, PW_SLP = 2'h2;
   // command codes
   localparam logic [7:0] CM_RD = 8'h20, CM_RD1 = 8'h21, CM_RL = 8'h22, CM_RL1 = 8'h23;
   localparam logic [7:0] CM_WR = 8'h30, CM_WR1 = 8'h31, CM_WL = 8'h32, CM_WL1 = 8'h33;
   localparam logic [7:0] CM_WNE = 8'h38, CM_WV = 8'h3C, CM_VR = 8'h40, CM_VR1 = 8'h41;
   localparam logic [7:0] CM_RM = 8'hC4, CM_WM = 8'hC5, CM_WMNE = 8'hCD, CM_SM = 8'hC6;
   // recalibrate and seek match on the high nibble only, see ace_decode
   localparam logic [7:0] CM_REC = 8'h10, CM_SEEK = 8'h70, CM_ID = 8'hEC, CM_SF = 8'hEF;
   localparam logic [7:0] CM_IDL = 8'hE3, CM_IDL1 = 8'h97, CM_IDI = 8'hE1, CM_IDI1 = 8'h95;
   localparam logic [7:0] CM_SLP = 8'hE6, CM_SLP1 = 8'h99, CM_SB = 8'hE2, CM_SB1 = 8'h96;
   localparam logic [7:0] CM_SBI = 8'hE0, CM_SBI1 = 8'h94, CM_WEAR = 8'hF5;
   localparam logic [7:0] CM_CHK = 8'hE5, CM_CHK1 = 8'h98, CM_DIAG = 8'h90, CM_ERS = 8'hC0;
   localparam logic [7:0] CM_INIT = 8'h91, CM_SENSE = 8'h03, CM_FMT = 8'h50;
   localparam logic [7:0] CM_XLAT = 8'h87, CM_BRD = 8'hE4, CM_BWR = 8'hE8;

   typedef enum {S_IDLE, S_EXEC, S_XFER, S_PROG, S_VRFY} ace_state_e;
   typedef enum logic [4:0] {CL_BAD, CL_NOP, CL_RD, CL_WR, CL_VRF, CL_ID, CL_SEEK,
      CL_FEAT, CL_MULT, CL_IDLE, CL_IDLI, CL_SLP, CL_STBY, CL_WEAR, CL_BRD, CL_BWR,
      CL_CHK} ace_cls_e;
   typedef struct packed {
      ace_cls_e cls;
      logic lng; // 516-byte sectors
      logic mlt; // block interrupts
      logic noer; // no erase before program
      logic vfy; // verify after program
   } ace_cmd_s;
   typedef struct packed {
      logic rd; // word consumed
      logic wr; // word delivered on wdata
      logic prog; // sector complete, program it
      logic erase; // erase before program
      logic vfy; // verify after program
      logic [27:0] lba; // sector address
      logic [15:0] wdata;
   } ace_med_s;

   // command code to class and flags
   function automatic ace_cmd_s ace_decode(input logic [7:0] c);
      ace_cmd_s d;
      d = '0;
      unique case (c)
         CM_RD, CM_RD1: d.cls = CL_RD;
         CM_RL, CM_RL1: d = '{CL_RD, 1'b1, 1'b0, 1'b0, 1'b0};
         CM_RM: d = '{CL_RD, 1'b0, 1'b1, 1'b0, 1'b0};
         CM_WR, CM_WR1: d.cls = CL_WR;
         CM_WL, CM_WL1: d = '{CL_WR, 1'b1, 1'b0, 1'b0, 1'b0};
         CM_WM: d = '{CL_WR, 1'b0, 1'b1, 1'b0, 1'b0};
         CM_WMNE: d = '{CL_WR, 1'b0, 1'b1, 1'b1, 1'b0};
         CM_WNE: d = '{CL_WR, 1'b0, 1'b0, 1'b1, 1'b0};
         CM_WV: d = '{CL_WR, 1'b0, 1'b0, 1'b0, 1'b1};
         CM_VR, CM_VR1: d.cls = CL_VRF;
         CM_ID: d.cls = CL_ID;
         CM_SF: d.cls = CL_FEAT;
         CM_SM: d.cls = CL_MULT;
         CM_IDL, CM_IDL1: d.cls = CL_IDLE;
         CM_IDI, CM_IDI1: d.cls = CL_IDLI;
         CM_SLP, CM_SLP1: d.cls = CL_SLP;
         CM_SB, CM_SB1, CM_SBI, CM_SBI1: d.cls = CL_STBY;
         CM_WEAR: d.cls = CL_WEAR;
         CM_CHK, CM_CHK1: d.cls = CL_CHK;
         CM_BRD, CM_XLAT: d.cls = CL_BRD;
         CM_BWR, CM_FMT: d.cls = CL_BWR;
         CM_DIAG, CM_ERS, CM_INIT, CM_SENSE: d.cls = CL_NOP;
         // low nibble of recalibrate and seek is free
         default: d.cls = (c[7:4] == CM_REC[7:4]) ? CL_NOP :
            (c[7:4] == CM_SEEK[7:4]) ? CL_SEEK : CL_BAD;
      endcase
      return d;
   endfunction
endpackage

// file: tb/ace_engine_tb_top.sv
// bench for the command engine: ahb-lite master, media model, checks
// assumes: zero-wait slave, one clock at 40 MHz
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin mismatches++; \
   $display("MISMATCH %s exp %h got %h", n, e, s); end end
module ace_engine_tb_top;
   import ace_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq_n;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = '0;
   logic [15:0] med_rdata;
   logic [7:0] sc;
   logic [31:0] wd, tot;
   logic [7:0] pc [6] = '{8'hE3, 8'hE3, 8'hE1, 8'hE6, 8'hE2, 8'hE0};
   logic [1:0] pp [6] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
   ace_med_s med;
   int mismatches = 0, n_compared = 0, seed = 88, i;
   int n_wr = 0, n_prog = 0;
   always #12.5 hclk = ~hclk;
   // media strobe counters for the write checks
   always @(posedge hclk) begin
      n_wr += med.wr;
      n_prog += med.prog;
   end
   ace_engine DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .irq_n(irq_n), .med(med), .med_rdata(med_rdata));
   ace_media_model MED (.hclk(hclk), .hresetn(hresetn), .med(med), .med_rdata(med_rdata));
   ////////////////////////////////////////////////////////////////////////////
   // one single word transfer; entered just after a rising edge
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      hsize <= HSIZE_WORD;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask
   // issue a command and poll alt status, which leaves the irq alone
   task cmd(input logic [7:0] c, input logic [7:0] n);
      bus(1, RA_SCNT, {24'h0, n}); bus(1, RA_CMD, {24'h0, c}); bus(0, RA_DCTL, 0);
      for (int t = 0; t < 40 && q[7] !== 1'b0; t++) bus(0, RA_DCTL, 0);
      @(posedge hclk);
   endtask
   // identify words worked out from the parameter block layout
   function automatic logic [15:0] id_exp(input int w, input logic [31:0] t);
      case (w)
         0: return 16'h848A; 7: return t[31:16]; 8: return t[15:0];
         20, 21: return 16'h0002; 22: return 16'h0004; 47: return 16'h0001;
         49: return 16'h0200; 51: return 16'h0100; default: return 16'h0000;
      endcase
   endfunction
   task give_verdict;
      if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #1_000_000; mismatches++; give_verdict;
   end
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // power commands, idle first with zero then a random nonzero count
      for (i = 0; i < 6; i++) begin
         sc = (i == 1) ? ($random(seed) | 8'h01) : 8'h00;
         cmd(pc[i], sc);
         `CHK("irq", 1'b0, irq_n)
         bus(0, RA_MODE, 0);
         `CHK("power", pp[i], q[6:5])
         if (i < 2) `CHK("apd", i[0], q[4])
         bus(0, RA_CMD, 0);
         @(posedge hclk);
         `CHK("irq clr", 1'b1, irq_n)
      end
      // interrupt disable holds the line off
      bus(1, RA_DCTL, 32'h2); cmd(8'hE1, 0);
      `CHK("nien", 1'b1, irq_n)
      bus(1, RA_DCTL, 32'h0); bus(0, RA_CMD, 0);
      // unsupported code aborts with an interrupt, then wear level clears the sector count
      cmd(8'h00, 0);
      `CHK("bad st", 2'b01, {q[3], q[0]})
      bus(0, RA_FEAT, 0);
      `CHK("bad er", 8'h04, q[7:0])
      cmd(8'hF5, $random(seed)); bus(0, RA_SCNT, 0);
      `CHK("wear", 8'h00, q[7:0])
      // identify block comes out as a data transfer; total sectors drawn at random
      tot = $random(seed) | 32'h0000_1000;
      bus(1, RA_TOTS, tot);
      cmd(8'hEC, 0);
      `CHK("id drq", 1'b1, q[3])
      for (i = 0; i < 256; i++) begin
         bus(0, RA_DATA, 0);
         if (i inside {0, 7, 8, 20, 21, 22, 47, 49, 51, 52}) begin
            `CHK("id", id_exp(i, tot), q[15:0])
         end
      end
      // one sector read from the reset sector number, words straight from the media
      bus(1, RA_DRVH, 32'h40);
      cmd(8'h20, 1);
      for (i = 0; i < 256; i++) begin
         bus(0, RA_DATA, 0);
         `CHK("rd", 16'(i) ^ 16'hA5A5, q[15:0])
      end
      bus(0, RA_DCTL, 0);
      `CHK("rd drq", 1'b0, q[3])
      `CHK("hresp", 1'b0, hresp)
      // one sector write without erase, random words, media strobes counted
      cmd(8'h38, 1);
      for (i = 0; i < 256; i++) begin
         wd = $random(seed);
         bus(1, RA_DATA, wd);
      end
      repeat (3) @(posedge hclk);
      `CHK("wr n", 256, n_wr)
      `CHK("prog n", 1, n_prog)
      `CHK("erase", 1'b0, med.erase)
      `CHK("wdata", wd[15:0], med.wdata)
      `CHK("wr irq", 1'b0, irq_n)
      // verify two sectors: busy only, never a data request
      cmd(8'h40, 2);
      `CHK("vrf st", 2'b00, {q[3], q[0]})
      `CHK("vrf irq", 1'b0, irq_n)
      // 8-bit mode kept over soft reset after 66H, dropped after CCH
      bus(1, RA_FEAT, 32'h01);
      cmd(8'hEF, 0);
      for (i = 0; i < 2; i++) begin
         bus(1, RA_FEAT, i ? 32'hCC : 32'h66);
         cmd(8'hEF, 0);
         bus(1, RA_DCTL, 32'h4);
         bus(0, RA_DCTL, 0);
         `CHK("srst bsy", 1'b1, q[7])
         bus(1, RA_DCTL, 32'h0);
         bus(0, RA_MODE, 0);
         `CHK("b8 keep", i == 0, q[2])
      end
      bus(0, RA_SCNT, 0);
      `CHK("srst sc", SC_RST, q[7:0])
      bus(0, RA_TOTS, 0);
      `CHK("srst tot", tot, q)
      // seek range check with a one-sector card, then a recalibrate
      bus(1, RA_TOTS, 32'h1);
      cmd(8'h7F, 0);
      bus(0, RA_FEAT, 0);
      `CHK("seek", ER_IDNF, q[7:0])
      cmd(8'h1A, 0);
      `CHK("recal", 1'b0, q[0])
      give_verdict;
   end
endmodule

// file: tb/ace_media_model.sv
// media side model: hands out one word per read strobe
// assumes: the next word must show while rd is high, for back-to-back reads
`timescale 1ns/1ps
module ace_media_model (
   input wire logic hclk, // bus clock
   input wire logic hresetn, // async reset, low
   input wire ace_pkg::ace_med_s med, // engine strobes
   output logic [15:0] med_rdata // current word
);
   logic [15:0] cnt_r;
   // the word moves on as soon as a strobe is seen, so a stale word is never read twice
   assign med_rdata = (cnt_r + {15'h0000, med.rd}) ^ 16'hA5A5;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) cnt_r <= 16'h0000;
      else if (med.rd) cnt_r <= cnt_r + 16'h0001;
   end
endmodule
